// ===== hdl/fsp_cfg.svh
// Offsets, field positions, reset values and cycle counts of the self-programming control.
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
`define FSP_OFS_CTRL_STATUS 12'h000
`define FSP_OFS_LOCK_BITS 12'h004
`define FSP_BIT_ARM 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_SECTION_READ_ENABLE 4
`define FSP_BIT_RSVD 5
`define FSP_BIT_BUSY 6
`define FSP_BIT_IRQ_EN 7
`define FSP_CTRL_RESET 8'h00
`define FSP_LOCK_RESET 8'hff
`define FSP_LOCK_KEEP 8'hc0
`define FSP_ERASED_WORD 16'hffff
`define FSP_BLOCKED_BYTE 8'hff
`define FSP_APP_VECTOR 16'h0000
`define FSP_PAT_LOAD 5'h01
`define FSP_PAT_ERASE 5'h03
`define FSP_PAT_WRITE 5'h05
`define FSP_PAT_LOCK 5'h09
`define FSP_PAT_SECTION_READ_ENABLE 5'h11
`define FSP_SPM_WINDOW 3'h4
`define FSP_LPM_WINDOW 3'h3
`endif

// ===== hdl/fsp_pkg.sv
// Types shared by the self-programming control and its environment.
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_ARMED = 2'b01,
        FSP_BUSY = 2'b11
    } fsp_state_t;
    typedef struct packed {
        logic section_read_enable;
        logic lock_set_cmd;
        logic page_write_cmd;
        logic page_erase_cmd;
    } fsp_cmd_t;
    typedef struct packed {
        logic req;
        logic erase;
        logic [15:0] page;
    } fsp_flash_op_t;
endpackage

// ===== hdl/fsp_ctrl.sv
// Flash self-programming control: command window, page buffer, lock bits and fuse readback.
//
// The register addresses and register access over APB were decided locally.
`include "fsp_cfg.svh"
module fsp_ctrl #(
    parameter int PAGE_WORDS = 32,
    parameter int NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 96,
    parameter logic [15:0] BOOT_VECTOR = 16'h0c00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic [15:0] pointer,
    input wire logic [7:0] data_reg_low,
    input wire logic [7:0] data_reg_high,
    input wire logic global_irq_flag,
    input wire logic eeprom_busy,
    input wire logic boot_reset_fuse,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    output fsp_pkg::fsp_flash_op_t flash_op,
    input wire logic flash_done,
    input wire logic [$clog2(PAGE_WORDS)-1:0] flash_buf_sel,
    output logic [15:0] flash_buf_word,
    output logic flash_rd_en,
    output logic [15:0] flash_rd_addr,
    input wire logic [7:0] flash_rd_byte,
    output logic [7:0] load_data,
    output logic load_valid,
    output logic ready_irq,
    output logic cpu_halt,
    output logic [15:0] reset_vector
);
    import fsp_pkg::*;

    localparam int WORD_BITS = $clog2(PAGE_WORDS);
    localparam int PAGE_BITS = 15 - WORD_BITS;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fsp_state_t state;
    fsp_cmd_t cmd;
    logic ready_irq_enable;
    logic section_busy_flag;
    logic [2:0] win_cnt;
    logic [7:0] lock_bits;
    logic [15:0] page_buf [PAGE_WORDS];
    logic buf_loaded;
    logic rd_pending;
    logic rd_blocked;

    logic bus_access;
    logic ctrl_wr;
    logic [4:0] wr_pat;
    logic pat_ok;
    logic spm_go;
    logic lpm_special;
    logic [PAGE_BITS-1:0] ptr_page;
    logic [WORD_BITS-1:0] ptr_word;
    logic ptr_in_no_read_while_write_area;
    logic [7:0] status_byte;
    logic load_abort;
    logic cmd_take;
    logic op_start;
    logic win_end;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign bus_access = psel && penable && pready;
    assign ctrl_wr = bus_access && pwrite && (paddr == `FSP_OFS_CTRL_STATUS);
    assign wr_pat = pwdata[4:0];
    assign pat_ok = (wr_pat == `FSP_PAT_LOAD) || (wr_pat == `FSP_PAT_ERASE) ||
                    (wr_pat == `FSP_PAT_WRITE) || (wr_pat == `FSP_PAT_LOCK) ||
                    (wr_pat == `FSP_PAT_SECTION_READ_ENABLE);
    // Pointer bit 0 is dropped for word addressing.
    assign ptr_word = pointer[WORD_BITS:1];
    assign ptr_page = pointer[15:WORD_BITS+1];
    assign ptr_in_no_read_while_write_area = ({{(16-PAGE_BITS){1'b0}}, ptr_page} >= 16'(NO_READ_WHILE_WRITE_AREA_FIRST_PAGE));
    // The window counter runs from the control write; four edges for stores.
    assign spm_go = (state == FSP_ARMED) && store_program_instr;
    assign lpm_special = (state == FSP_ARMED) && cmd.lock_set_cmd && load_program_instr &&
                         (win_cnt < `FSP_LPM_WINDOW);
    // A read-enable write outside the busy state, with the EEPROM idle, throws away words sitting in the buffer.
    assign load_abort = ctrl_wr && pwdata[`FSP_BIT_SECTION_READ_ENABLE] && buf_loaded &&
                        (state != FSP_BUSY) && !eeprom_busy;
    assign status_byte = {ready_irq_enable, section_busy_flag, 1'b0, cmd.section_read_enable,
                          cmd.lock_set_cmd, cmd.page_write_cmd, cmd.page_erase_cmd,
                          state != FSP_IDLE};

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait cycle lets read data come from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                if (paddr == `FSP_OFS_CTRL_STATUS) begin
                    prdata <= {24'h00_0000, status_byte};
                end else if (paddr == `FSP_OFS_LOCK_BITS && !pwrite) begin
                    prdata <= {24'h00_0000, lock_bits};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_irq_enable <= 1'(`FSP_CTRL_RESET >> `FSP_BIT_IRQ_EN);
        end else if (ctrl_wr) begin
            ready_irq_enable <= pwdata[`FSP_BIT_IRQ_EN];
        end
    end

    // ------------------------------------------------------------
    // Command window and sequencing
    // ------------------------------------------------------------
    assign cmd_take = ctrl_wr && pat_ok && !eeprom_busy;
    assign op_start = spm_go && (cmd.page_erase_cmd || cmd.page_write_cmd);
    assign win_end = (win_cnt == `FSP_SPM_WINDOW - 3'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= FSP_IDLE;
        end else begin
            case (state)
                FSP_IDLE: begin
                    if (cmd_take) begin
                        state <= FSP_ARMED;
                    end
                end
                FSP_ARMED: begin
                    if (op_start) begin
                        state <= FSP_BUSY;
                    end else if (spm_go || lpm_special) begin
                        state <= FSP_IDLE;
                    end else if (!cmd_take && win_end) begin
                        state <= FSP_IDLE;
                    end
                end
                FSP_BUSY: begin
                    // Control writes cannot touch the command here, so read-enable is lost.
                    if (flash_done) begin
                        state <= FSP_IDLE;
                    end
                end
                default: begin
                    state <= FSP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= '0;
        end else begin
            case (state)
                FSP_IDLE: begin
                    if (cmd_take) begin
                        cmd <= fsp_cmd_t'(wr_pat[4:1]);
                    end
                end
                FSP_ARMED: begin
                    if (spm_go) begin
                        if (!op_start) begin
                            cmd <= '0;
                        end
                    end else if (lpm_special || (!cmd_take && win_end)) begin
                        cmd <= '0;
                    end else if (cmd_take) begin
                        cmd <= fsp_cmd_t'(wr_pat[4:1]);
                    end
                end
                FSP_BUSY: begin
                    if (flash_done) begin
                        cmd <= '0;
                    end
                end
                default: begin
                    cmd <= '0;
                end
            endcase
        end
    end

    // Entry to the armed state always starts the count from zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= 3'h0;
        end else if (state != FSP_ARMED) begin
            win_cnt <= 3'h0;
        end else if (!spm_go && !lpm_special) begin
            if (cmd_take) begin
                win_cnt <= 3'h0;
            end else if (!win_end) begin
                win_cnt <= win_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_op <= '0;
        end else if (op_start) begin
            flash_op.req <= 1'b1;
            flash_op.erase <= cmd.page_erase_cmd;
            flash_op.page <= 16'(ptr_page);
        end else if (state != FSP_BUSY || flash_done) begin
            flash_op.req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Section busy and CPU halt
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            section_busy_flag <= 1'b0;
            cpu_halt <= 1'b0;
        end else begin
            if (spm_go && (cmd.page_erase_cmd || cmd.page_write_cmd)) begin
                if (ptr_in_no_read_while_write_area) begin
                    cpu_halt <= 1'b1;
                end else begin
                    section_busy_flag <= 1'b1;
                end
            end else if (spm_go && (cmd == '0)) begin
                section_busy_flag <= 1'b0;
            end else if (spm_go && cmd.section_read_enable) begin
                section_busy_flag <= 1'b0;
            end
            if (state == FSP_BUSY && flash_done) begin
                cpu_halt <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Temporary page buffer
    // ------------------------------------------------------------
    // Clearing all words at once costs area but keeps the clear to a single cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                page_buf[i] <= `FSP_ERASED_WORD;
            end
            buf_loaded <= 1'b0;
        end else begin
            if (load_abort || (spm_go && cmd.section_read_enable) ||
                (state == FSP_BUSY && flash_done && !flash_op.erase)) begin
                for (int i = 0; i < PAGE_WORDS; i++) begin
                    page_buf[i] <= `FSP_ERASED_WORD;
                end
                buf_loaded <= 1'b0;
            end else if (spm_go && (cmd == '0)) begin
                page_buf[ptr_word] <= {data_reg_high, data_reg_low};
                buf_loaded <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_buf_word <= `FSP_ERASED_WORD;
        end else begin
            flash_buf_word <= page_buf[flash_buf_sel];
        end
    end

    // ------------------------------------------------------------
    // Lock bits
    // ------------------------------------------------------------
    // Bits can only be programmed to zero; only a reset returns them to ones.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_bits <= `FSP_LOCK_RESET;
        end else if (spm_go && cmd.lock_set_cmd) begin
            lock_bits <= lock_bits & (data_reg_low | `FSP_LOCK_KEEP);
        end
    end

    // ------------------------------------------------------------
    // Program memory loads
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_rd_en <= 1'b0;
            flash_rd_addr <= 16'h0000;
            rd_pending <= 1'b0;
            rd_blocked <= 1'b0;
            load_data <= 8'h00;
            load_valid <= 1'b0;
        end else begin
            flash_rd_en <= 1'b0;
            load_valid <= 1'b0;
            if (lpm_special) begin
                load_valid <= 1'b1;
                if (eeprom_busy) begin
                    load_data <= `FSP_BLOCKED_BYTE;
                end else if (pointer[1:0] == 2'h1) begin
                    load_data <= lock_bits;
                end else if (pointer[1:0] == 2'h3) begin
                    load_data <= fuse_high;
                end else begin
                    load_data <= fuse_low;
                end
            end else if (load_program_instr) begin
                flash_rd_en <= 1'b1;
                flash_rd_addr <= pointer;
                rd_pending <= 1'b1;
                rd_blocked <= section_busy_flag && !ptr_in_no_read_while_write_area;
            end else if (rd_pending) begin
                rd_pending <= 1'b0;
                load_valid <= 1'b1;
                load_data <= rd_blocked ? `FSP_BLOCKED_BYTE : flash_rd_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt request and reset vector
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_irq <= 1'b0;
            reset_vector <= `FSP_APP_VECTOR;
        end else begin
            ready_irq <= ready_irq_enable && global_irq_flag && (state == FSP_IDLE);
            // Fuses are inputs only; nothing here can write them.
            reset_vector <= boot_reset_fuse ? `FSP_APP_VECTOR : BOOT_VECTOR;
        end
    end
endmodule

// ===== testbench/fsp_flash_model.sv
// Behavioural flash array standing behind the self-programming control.
module fsp_flash_model #(
    parameter int DELAY = 12
) (
    input wire logic pclk,
    input wire fsp_pkg::fsp_flash_op_t flash_op,
    input wire logic flash_rd_en,
    input wire logic [15:0] flash_rd_addr,
    output logic flash_done,
    output logic [7:0] flash_rd_byte
);
    import fsp_pkg::*;
    int cnt = 0;
    logic [7:0] noise = 8'h00;
    initial flash_done = 1'b0;
    // The byte stands while the read strobe is high; otherwise it toggles, so a late
    // sample shows up.
    assign flash_rd_byte = flash_rd_en ? (flash_rd_addr[7:0] ^ 8'h5a) : noise;
    always @(posedge pclk) begin
        flash_done <= (cnt == DELAY);
        cnt <= (flash_op.req && !flash_done) ? cnt + 1 : 0;
        noise <= ~noise;
    end
endmodule

// ===== testbench/fsp_ctrl_properties.sv
// Port-level checker for the flash self-programming control.
module fsp_ctrl_properties #(
    parameter int NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 96,
    parameter logic [15:0] BOOT_VECTOR = 16'h0c00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic [15:0] pointer,
    input wire logic global_irq_flag,
    input wire logic boot_reset_fuse,
    input wire fsp_pkg::fsp_flash_op_t flash_op,
    input wire logic flash_done,
    input wire logic flash_rd_en,
    input wire logic [15:0] flash_rd_addr,
    input wire logic load_valid,
    input wire logic ready_irq,
    input wire logic cpu_halt,
    input wire logic [15:0] reset_vector
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apb_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("bus wait state wrong");
    property p_irq; ready_irq |-> $past(global_irq_flag); endproperty
    a_irq: assert property (p_irq) else $error("ready irq without global flag");
    property p_start; $rose(flash_op.req) |-> $past(store_program_instr)
        && flash_op.page == ($past(pointer) >> 6); endproperty
    a_start: assert property (p_start) else $error("operation start wrong");
    property p_hold; flash_op.req && !flash_done |=> flash_op.req; endproperty
    a_hold: assert property (p_hold) else $error("operation dropped early");
    property p_latch; flash_op.req && $past(flash_op.req) |-> $stable(flash_op.page); endproperty
    a_latch: assert property (p_latch) else $error("page not latched");
    property p_halt; $rose(cpu_halt) |-> flash_op.req && flash_op.page >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE;
    endproperty
    a_halt: assert property (p_halt) else $error("halt outside locked area");
    property p_rd; flash_rd_en |-> $past(load_program_instr) && flash_rd_addr == $past(pointer);
    endproperty
    a_rd: assert property (p_rd) else $error("read address wrong");
    property p_ldv; flash_rd_en |=> load_valid; endproperty
    a_ldv: assert property (p_ldv) else $error("load result missing");
    property p_vec; 1'b1 |=> reset_vector == ($past(boot_reset_fuse) ? 16'h0000 : BOOT_VECTOR);
    endproperty
    a_vec: assert property (p_vec) else $error("reset vector wrong");
    c_halt: cover property (cpu_halt);
    c_done: cover property (flash_done);
    c_load: cover property (load_valid && !$past(flash_rd_en));
endmodule
bind fsp_ctrl fsp_ctrl_properties #(.NO_READ_WHILE_WRITE_AREA_FIRST_PAGE(NO_READ_WHILE_WRITE_AREA_FIRST_PAGE),
    .BOOT_VECTOR(BOOT_VECTOR)) u_fsp_ctrl_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready),
    .store_program_instr(store_program_instr), .load_program_instr(load_program_instr),
    .pointer(pointer), .global_irq_flag(global_irq_flag), .boot_reset_fuse(boot_reset_fuse),
    .flash_op(flash_op), .flash_done(flash_done), .flash_rd_en(flash_rd_en),
    .flash_rd_addr(flash_rd_addr), .load_valid(load_valid), .ready_irq(ready_irq),
    .cpu_halt(cpu_halt), .reset_vector(reset_vector));

// ===== testbench/fsp_ctrl_test.sv
// Self-checking bench for the flash self-programming control.
module fsp_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fsp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic store_program_instr, load_program_instr, global_irq_flag, eeprom_busy;
    logic boot_reset_fuse, flash_done, flash_rd_en, load_valid, ready_irq, cpu_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] pointer, flash_buf_word, flash_rd_addr, reset_vector;
    logic [7:0] data_reg_low, data_reg_high, fuse_low, fuse_high, flash_rd_byte, load_data, got;
    logic [4:0] flash_buf_sel;
    fsp_flash_op_t flash_op;
    int failures = 0;
    int n_compared = 0;
    fsp_ctrl u_fsp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .store_program_instr(store_program_instr),
        .load_program_instr(load_program_instr), .pointer(pointer),
        .data_reg_low(data_reg_low), .data_reg_high(data_reg_high),
        .global_irq_flag(global_irq_flag), .eeprom_busy(eeprom_busy),
        .boot_reset_fuse(boot_reset_fuse), .fuse_low(fuse_low), .fuse_high(fuse_high),
        .flash_op(flash_op), .flash_done(flash_done), .flash_buf_sel(flash_buf_sel),
        .flash_buf_word(flash_buf_word), .flash_rd_en(flash_rd_en),
        .flash_rd_addr(flash_rd_addr), .flash_rd_byte(flash_rd_byte),
        .load_data(load_data), .load_valid(load_valid), .ready_irq(ready_irq),
        .cpu_halt(cpu_halt), .reset_vector(reset_vector));
    fsp_flash_model #(.DELAY(40)) u_fsp_flash_model (.pclk(pclk), .flash_op(flash_op),
        .flash_rd_en(flash_rd_en), .flash_rd_addr(flash_rd_addr), .flash_done(flash_done),
        .flash_rd_byte(flash_rd_byte));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (load_valid === 1'b1) got <= load_data;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // The extra edge at the end keeps back-to-back calls from driving psel twice at once.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic ins(input logic st, input logic [15:0] p, input logic [15:0] d);
        store_program_instr <= st;
        load_program_instr <= !st;
        pointer <= p;
        {data_reg_high, data_reg_low} <= d;
        @(posedge pclk);
        store_program_instr <= 1'b0;
        load_program_instr <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic cmd(input logic [7:0] c, input logic st, input logic [15:0] p,
        input logic [15:0] d);
        apb(1'b1, 12'h000, {24'h0, c});
        ins(st, p, d);
    endtask
    task automatic buf_is(input logic [4:0] i, input logic [15:0] w);
        flash_buf_sel <= i;
        repeat (2) @(posedge pclk);
        chk(flash_buf_word, w);
    endtask
    task automatic wait_idle;
        for (int n = 0; n < 100 && flash_op.req !== 1'b0; n++) @(posedge pclk);
        chk(flash_op.req, 1'b0);
    endtask
    task automatic t_regs;
        rdc(12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        chk(er, 1'b1);
        rdc(12'h004, 32'hff);
        apb(1'b1, 12'h000, 32'ha6);
        rdc(12'h000, 32'h80);
        chk(ready_irq, 1'b1);
        apb(1'b1, 12'h000, 32'h81);
        @(posedge pclk);
        chk(ready_irq, 1'b0);
        repeat (4) @(posedge pclk);
        chk(ready_irq, 1'b1);
        global_irq_flag <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(ready_irq, 1'b0);
        global_irq_flag <= 1'b1;
    endtask
    task automatic t_load;
        cmd(8'h81, 1'b1, 16'h000b, 16'h1234);
        buf_is(5'd5, 16'h1234);
        cmd(8'h87, 1'b1, 16'h000b, 16'h0000);
        buf_is(5'd5, 16'h1234);
        eeprom_busy <= 1'b1;
        cmd(8'h81, 1'b1, 16'h000b, 16'h0000);
        eeprom_busy <= 1'b0;
        buf_is(5'd5, 16'h1234);
        apb(1'b1, 12'h000, 32'h90);
        buf_is(5'd5, 16'hffff);
    endtask
    task automatic t_rww;
        cmd(8'h81, 1'b1, 16'h0004, 16'hbeef);
        cmd(8'h83, 1'b1, 16'h00c0, 16'h0000);
        chk(flash_op, 18'h30003);
        rdc(12'h000, 32'hc3);
        apb(1'b1, 12'h000, 32'h91);
        rdc(12'h000, 32'hc3);
        ins(1'b0, 16'h0010, 16'h0000);
        chk(got, 8'hff);
        wait_idle;
        rdc(12'h000, 32'hc0);
        cmd(8'h85, 1'b1, 16'h00c0, 16'h0000);
        chk(flash_op, 18'h20003);
        wait_idle;
        buf_is(5'd2, 16'hffff);
        cmd(8'h91, 1'b1, 16'h0000, 16'h0000);
        rdc(12'h000, 32'h80);
        ins(1'b0, 16'h0011, 16'h0000);
        chk(got, 8'h4b);
        apb(1'b1, 12'h000, 32'h83);
        repeat (4) @(posedge pclk);
        ins(1'b1, 16'h00c0, 16'h0000);
        chk(flash_op.req, 1'b0);
    endtask
    task automatic t_no_read_while_write_area;
        cmd(8'h83, 1'b1, 16'h1900, 16'h0000);
        chk(cpu_halt, 1'b1);
        rdc(12'h000, 32'h83);
        wait_idle;
        @(posedge pclk);
        chk(cpu_halt, 1'b0);
    endtask
    task automatic t_lock;
        cmd(8'h89, 1'b1, 16'hffff, 16'hff00);
        rdc(12'h004, 32'hc0);
        cmd(8'h89, 1'b0, 16'h0001, 16'h0000);
        chk(got, 8'hc0);
        cmd(8'h89, 1'b0, 16'h0000, 16'h0000);
        chk(got, 8'h3c);
        cmd(8'h89, 1'b0, 16'h0003, 16'h0000);
        chk(got, 8'hd9);
    endtask
    task automatic t_reset;
        chk(reset_vector, 16'h0c00);
        cmd(8'h81, 1'b1, 16'h000e, 16'h5555);
        boot_reset_fuse <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(reset_vector, 16'h0000);
        buf_is(5'd7, 16'hffff);
    endtask
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, store_program_instr, load_program_instr, eeprom_busy} = '0;
        {paddr, pwdata, pointer, data_reg_low, data_reg_high, flash_buf_sel} = '0;
        {global_irq_flag, boot_reset_fuse, fuse_low, fuse_high} = {2'b10, 16'h3cd9};
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_load;
        t_rww;
        t_no_read_while_write_area;
        t_lock;
        t_reset;
        end_of_test;
    end
    initial begin
        #100000;
        failures++;
        end_of_test;
    end
endmodule
